// ===== logic/dmx_pkg.sv
// Opcodes, timing constants and shared types of the data-move executor
package dmx_pkg;

   // Opcode encodings handled by the executor
   localparam logic [7:0] OPC_BIT_TO_CARRY = 8'ha2;
   localparam logic [7:0] OPC_CARRY_TO_BIT = 8'h92;
   localparam logic [7:0] OPC_LOAD_DP      = 8'h90;
   localparam logic [6:0] OPC_IDX_IMM_HI   = 7'h3b;  // 0111011i
   localparam logic [7:0] OPC_CODE_RD_DP   = 8'h93;
   localparam logic [7:0] OPC_CODE_RD_PC   = 8'h83;
   localparam logic [7:0] OPC_CODE_WR      = 8'ha5;
   localparam logic [6:0] OPC_XRD_IDX_HI   = 7'h71;  // 1110001i
   localparam logic [6:0] OPC_XWR_IDX_HI   = 7'h79;  // 1111001i
   localparam logic [7:0] OPC_XRD_DP       = 8'he0;
   localparam logic [7:0] OPC_XWR_DP       = 8'hf0;

   // Machine cycle length and per-instruction machine cycles
   localparam logic [2:0] CLK_PER_MC = 3'h2;
   localparam logic [2:0] MC_ONE     = 3'h1;
   localparam logic [2:0] MC_TWO     = 3'h2;

   // Clock of a multi-cycle access at which read data is sampled
   localparam logic [2:0] RD_SAMPLE_CNT = 3'h2;

   // Step from a one-byte instruction to the next one
   localparam logic [15:0] PC_STEP_ONE = 16'h0001;

   // Bit-addressable internal RAM window
   localparam logic [7:0] BIT_AREA_BASE = 8'h20;

   // Reset values
   localparam logic [7:0]  ACCUM_RESET = 8'h00;
   localparam logic [15:0] DP_RESET    = 16'h0000;

   // Decoded instruction kinds
   typedef enum logic [3:0] {
      OP_NONE        = 4'b0000,
      OP_BIT_TO_C    = 4'b0001,
      OP_C_TO_BIT    = 4'b0010,
      OP_LOAD_DP     = 4'b0011,
      OP_IDX_IMM     = 4'b0100,
      OP_CODE_RD_DP  = 4'b0101,
      OP_CODE_RD_PC  = 4'b0110,
      OP_CODE_WR     = 4'b0111,
      OP_TRAP        = 4'b1000,
      OP_XRD_IDX     = 4'b1001,
      OP_XWR_IDX     = 4'b1010,
      OP_XRD_DP      = 4'b1011,
      OP_XWR_DP      = 4'b1100
   } dmx_op_t;

   // Executor states
   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_EXEC = 1'b1
   } dmx_state_t;

   // One instruction as presented by the fetch unit
   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] byte2;
      logic [7:0] byte3;
   } dmx_instr_t;

endpackage : dmx_pkg

// ===== logic/dmx_data_move_exec.sv
// Decode and execute logic for the data-move instruction group
// Behaviour
// - Bit move copies bit, nothing else changes
// - Bit-to-carry: two bytes, one machine cycle
// - Carry-to-bit: two bytes, two machine cycles
// - Pointer load: byte2 high, byte3 low
// - Immediate to indirect RAM, one cycle
// - Code read address accumulator plus base
// - Program counter base advanced before add
// - Pointer-relative code read, two cycles
// - Counter-relative code read, two cycles
// - Code write then pointer increments
// - Code write opcode a5, two cycles
// - Trap enable turns code write into trap
// - Short external move uses index byte
// - Long external move uses pointer bytes
// - Address port latches stay unmodified
// - External read via index, two cycles
// - External write via index, two cycles
// - External write via pointer, two cycles
// - External read via pointer is e0
`timescale 1ns/1ns
module dmx_data_move_exec
   import dmx_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // Instruction issue
   input  wire logic        start,
   input  wire dmx_instr_t  instr,
   input  wire logic [15:0] pc,
   input  wire logic [1:0]  regBank,
   input  wire logic        trapEnableBit,
   output logic             busy,
   output logic             done,
   output logic             trapReq,
   output logic             illegal,
   // Architectural state
   output logic [7:0]       accumulator,
   output logic             carry,
   output logic [15:0]      dataPointer,
   // Core-side internal RAM write port
   input  wire logic        iramExtWe,
   input  wire logic [7:0]  iramExtAddr,
   input  wire logic [7:0]  iramExtData,
   // Special function bit access
   output logic [7:0]       sfrBitAddr,
   output logic             sfrBitWr,
   output logic             sfrBitWdata,
   input  wire logic        sfrBitIn,
   // Program memory
   output logic [15:0]      codeAddr,
   output logic             codeRd,
   output logic             codeWr,
   output logic [7:0]       codeWdata,
   input  wire logic [7:0]  codeRdata,
   // External data memory
   input  wire logic [7:0]  portHiLatch,
   output logic [15:0]      xAddr,
   output logic             xRd,
   output logic             xWr,
   output logic [7:0]       xWdata,
   input  wire logic [7:0]  xRdata
);

   // Control state
   dmx_state_t  state_q,      state_d;      // Idle or executing
   dmx_op_t     op_q,         op_d;         // Kind in flight
   dmx_instr_t  instr_q,      instr_d;      // Captured instruction
   logic [2:0]  cnt_q,        cnt_d;        // Clock within instruction
   logic [2:0]  total_q,      total_d;      // Clocks of instruction
   logic [7:0]  rdLatch_q,    rdLatch_d;    // Sampled read byte
   // Architectural registers
   logic [7:0]  accum_q,      accum_d;      // Accumulator
   logic        carry_q,      carry_d;      // Carry flag
   logic [15:0] dp_q,         dp_d;         // Data pointer
   // Output strobes and buses
   logic        done_q,       done_d;
   logic        trap_q,       trap_d;
   logic        illegal_q,    illegal_d;
   logic [7:0]  bitAddr_q,    bitAddr_d;
   logic        bitWr_q,      bitWr_d;
   logic        bitWdata_q,   bitWdata_d;
   logic [15:0] codeAddr_q,   codeAddr_d;
   logic        codeRd_q,     codeRd_d;
   logic        codeWr_q,     codeWr_d;
   logic [7:0]  codeWdata_q,  codeWdata_d;
   logic [15:0] xAddr_q,      xAddr_d;
   logic        xRd_q,        xRd_d;
   logic        xWr_q,        xWr_d;
   logic [7:0]  xWdata_q,     xWdata_d;

   // Internal RAM and its write port from this executor
   logic [7:0]  iram [256];
   logic        iramWe;
   logic [7:0]  iramWaddr;
   logic [7:0]  iramWdata;

   // Helpers
   dmx_op_t     newOp;                     // Decode of incoming opcode
   logic        startTaken;                // Request accepted this edge
   logic [7:0]  idxValNew;                 // Index byte for new instr
   logic [7:0]  idxValCur;                 // Index byte for instr held
   logic [7:0]  bitByteAddr;               // RAM byte holding the bit
   logic [7:0]  bitByte;                   // That byte
   logic        bitVal;                    // Current value of the bit

   // Address of an index register within the selected bank
   function automatic logic [7:0] idxAddr(input logic [1:0] bank,
                                          input logic       sel);
      idxAddr = {3'h0, bank, 2'h0, sel};
   endfunction : idxAddr

   // Opcode decode; code write yields to trap when enabled
   function automatic dmx_op_t decodeOp(input logic [7:0] opc,
                                        input logic       trapEn);
      decodeOp = OP_NONE;
      if (opc == OPC_BIT_TO_CARRY)          decodeOp = OP_BIT_TO_C;
      else if (opc == OPC_CARRY_TO_BIT)     decodeOp = OP_C_TO_BIT;
      else if (opc == OPC_LOAD_DP)          decodeOp = OP_LOAD_DP;
      else if (opc[7:1] == OPC_IDX_IMM_HI)  decodeOp = OP_IDX_IMM;
      else if (opc == OPC_CODE_RD_DP)       decodeOp = OP_CODE_RD_DP;
      else if (opc == OPC_CODE_RD_PC)       decodeOp = OP_CODE_RD_PC;
      else if (opc == OPC_CODE_WR)
         decodeOp = trapEn ? OP_TRAP : OP_CODE_WR;
      else if (opc[7:1] == OPC_XRD_IDX_HI)  decodeOp = OP_XRD_IDX;
      else if (opc[7:1] == OPC_XWR_IDX_HI)  decodeOp = OP_XWR_IDX;
      else if (opc == OPC_XRD_DP)           decodeOp = OP_XRD_DP;
      else if (opc == OPC_XWR_DP)           decodeOp = OP_XWR_DP;
   endfunction : decodeOp

   // Clocks per instruction kind
   function automatic logic [2:0] clocksOf(input dmx_op_t op);
      logic [2:0] mc;
      mc = MC_TWO;
      if (op == OP_BIT_TO_C || op == OP_IDX_IMM)
         mc = MC_ONE;
      clocksOf = 3'(mc * CLK_PER_MC);
   endfunction : clocksOf

   // Decode and bit lookup
   assign startTaken  = start && (state_q == ST_IDLE);
   assign newOp       = decodeOp(instr.opcode, trapEnableBit);
   assign idxValNew   = iram[idxAddr(regBank, instr.opcode[0])];
   assign idxValCur   = iram[idxAddr(regBank, instr_q.opcode[0])];
   assign bitByteAddr = BIT_AREA_BASE + {4'h0, bitAddr_q[6:3]};
   assign bitByte     = iram[bitByteAddr];
   assign bitVal      = bitAddr_q[7] ? sfrBitIn : bitByte[bitAddr_q[2:0]];

   // Next-state logic for the whole executor
   always_comb begin
      state_d     = state_q;
      op_d        = op_q;
      instr_d     = instr_q;
      cnt_d       = cnt_q;
      total_d     = total_q;
      rdLatch_d   = rdLatch_q;
      accum_d     = accum_q;
      carry_d     = carry_q;
      dp_d        = dp_q;
      bitAddr_d   = bitAddr_q;
      codeAddr_d  = codeAddr_q;
      codeWdata_d = codeWdata_q;
      xAddr_d     = xAddr_q;
      xWdata_d    = xWdata_q;
      bitWdata_d  = bitWdata_q;
      done_d      = 1'b0;
      trap_d      = 1'b0;
      illegal_d   = 1'b0;
      bitWr_d     = 1'b0;
      codeRd_d    = 1'b0;
      codeWr_d    = 1'b0;
      xRd_d       = 1'b0;
      xWr_d       = 1'b0;
      iramWe      = 1'b0;
      iramWaddr   = 8'h00;
      iramWdata   = 8'h00;
      unique case (state_q)
         ST_IDLE: begin
            if (start) begin
               if (newOp == OP_TRAP) begin
                  trap_d = 1'b1;
               end else if (newOp == OP_NONE) begin
                  illegal_d = 1'b1;
               end else begin
                  // Accept and launch the access
                  state_d = ST_EXEC;
                  op_d    = newOp;
                  instr_d = instr;
                  cnt_d   = 3'h1;
                  total_d = clocksOf(newOp);
                  unique case (newOp)
                     OP_BIT_TO_C, OP_C_TO_BIT: begin
                        bitAddr_d = instr.byte2;
                     end
                     OP_CODE_RD_DP: begin
                        codeAddr_d = dp_q + {8'h00, accum_q};
                        codeRd_d   = 1'b1;
                     end
                     OP_CODE_RD_PC: begin
                        codeAddr_d = pc + PC_STEP_ONE
                                   + {8'h00, accum_q};
                        codeRd_d   = 1'b1;
                     end
                     OP_CODE_WR: begin
                        codeAddr_d  = dp_q;
                        codeWdata_d = accum_q;
                        codeWr_d    = 1'b1;
                     end
                     OP_XRD_IDX, OP_XWR_IDX: begin
                        // High byte from the untouched port latch
                        xAddr_d = {portHiLatch, idxValNew};
                        xRd_d   = (newOp == OP_XRD_IDX);
                        xWr_d   = (newOp == OP_XWR_IDX);
                     end
                     OP_XRD_DP, OP_XWR_DP: begin
                        xAddr_d = dp_q;
                        xRd_d   = (newOp == OP_XRD_DP);
                        xWr_d   = (newOp == OP_XWR_DP);
                     end
                     default: begin
                        // Pointer load and immediate store act at commit
                     end
                  endcase
                  xWdata_d = accum_q;
               end
            end
         end
         ST_EXEC: begin
            cnt_d = cnt_q + 3'h1;
            // Read data arrives one clock after the strobe
            if (cnt_q == RD_SAMPLE_CNT) begin
               rdLatch_d = (op_q == OP_CODE_RD_DP || op_q == OP_CODE_RD_PC)
                         ? codeRdata : xRdata;
            end
            if (cnt_q == total_q - 3'h1) begin
               state_d = ST_IDLE;
               done_d  = 1'b1;
               unique case (op_q)
                  OP_BIT_TO_C: begin
                     carry_d = bitVal;
                  end
                  OP_C_TO_BIT: begin
                     if (bitAddr_q[7]) begin
                        bitWr_d    = 1'b1;
                        bitWdata_d = carry_q;
                     end else begin
                        iramWe    = 1'b1;
                        iramWaddr = bitByteAddr;
                        iramWdata = bitByte;
                        iramWdata[bitAddr_q[2:0]] = carry_q;
                     end
                  end
                  OP_LOAD_DP: begin
                     dp_d = {instr_q.byte2, instr_q.byte3};
                  end
                  OP_IDX_IMM: begin
                     iramWe    = 1'b1;
                     iramWaddr = idxValCur;
                     iramWdata = instr_q.byte2;
                  end
                  OP_CODE_RD_DP, OP_CODE_RD_PC, OP_XRD_IDX, OP_XRD_DP: begin
                     accum_d = rdLatch_q;
                  end
                  OP_CODE_WR: begin
                     dp_d = dp_q + 16'h0001;
                  end
                  default: begin
                     // External writes finish with no state change
                  end
               endcase
            end
         end
      endcase
   end

   // Register the executor state
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q     <= ST_IDLE;
         op_q        <= OP_NONE;
         instr_q     <= '0;
         cnt_q       <= 3'h0;
         total_q     <= 3'h0;
         rdLatch_q   <= 8'h00;
         accum_q     <= ACCUM_RESET;
         carry_q     <= 1'b0;
         dp_q        <= DP_RESET;
         done_q      <= 1'b0;
         trap_q      <= 1'b0;
         illegal_q   <= 1'b0;
         bitAddr_q   <= 8'h00;
         bitWr_q     <= 1'b0;
         bitWdata_q  <= 1'b0;
         codeAddr_q  <= 16'h0000;
         codeRd_q    <= 1'b0;
         codeWr_q    <= 1'b0;
         codeWdata_q <= 8'h00;
         xAddr_q     <= 16'h0000;
         xRd_q       <= 1'b0;
         xWr_q       <= 1'b0;
         xWdata_q    <= 8'h00;
      end else begin
         state_q     <= state_d;
         op_q        <= op_d;
         instr_q     <= instr_d;
         cnt_q       <= cnt_d;
         total_q     <= total_d;
         rdLatch_q   <= rdLatch_d;
         accum_q     <= accum_d;
         carry_q     <= carry_d;
         dp_q        <= dp_d;
         done_q      <= done_d;
         trap_q      <= trap_d;
         illegal_q   <= illegal_d;
         bitAddr_q   <= bitAddr_d;
         bitWr_q     <= bitWr_d;
         bitWdata_q  <= bitWdata_d;
         codeAddr_q  <= codeAddr_d;
         codeRd_q    <= codeRd_d;
         codeWr_q    <= codeWr_d;
         codeWdata_q <= codeWdata_d;
         xAddr_q     <= xAddr_d;
         xRd_q       <= xRd_d;
         xWr_q       <= xWr_d;
         xWdata_q    <= xWdata_d;
      end
   end

   // Internal RAM; executor writes win over the core port
   always_ff @(posedge clk) begin
      if (iramWe) begin
         iram[iramWaddr] <= iramWdata;
      end else if (iramExtWe) begin
         iram[iramExtAddr] <= iramExtData;
      end
   end

   // Outputs straight from flip-flops
   assign busy        = (state_q == ST_EXEC);
   assign done        = done_q;
   assign trapReq     = trap_q;
   assign illegal     = illegal_q;
   assign accumulator = accum_q;
   assign carry       = carry_q;
   assign dataPointer = dp_q;
   assign sfrBitAddr  = bitAddr_q;
   assign sfrBitWr    = bitWr_q;
   assign sfrBitWdata = bitWdata_q;
   assign codeAddr    = codeAddr_q;
   assign codeRd      = codeRd_q;
   assign codeWr      = codeWr_q;
   assign codeWdata   = codeWdata_q;
   assign xAddr       = xAddr_q;
   assign xRd         = xRd_q;
   assign xWr         = xWr_q;
   assign xWdata      = xWdata_q;

   // Timing and effect checks
   property p_bitNoSide;
      @(posedge clk) disable iff (!reset_n)
      startTaken && newOp == OP_BIT_TO_C |=> ##1 $stable(dp_q)
         && $stable(accum_q) && !codeWr_q && !xWr_q;
   endproperty
   a_bitNoSide: assert property (p_bitNoSide)
      else $error("bit move touched other state");

   property p_bitToCarry;
      @(posedge clk) disable iff (!reset_n)
      startTaken && newOp == OP_BIT_TO_C |-> ##2 done_q
         && carry_q == $past(bitVal);
   endproperty
   a_bitToCarry: assert property (p_bitToCarry)
      else $error("bit-to-carry wrong value or timing");

   property p_carryToBit;
      @(posedge clk) disable iff (!reset_n)
      startTaken && newOp == OP_C_TO_BIT |=> !done_q [*3] ##1 done_q;
   endproperty
   a_carryToBit: assert property (p_carryToBit)
      else $error("carry-to-bit not four clocks");

   property p_loadDp;
      @(posedge clk) disable iff (!reset_n)
      startTaken && newOp == OP_LOAD_DP |-> ##4 done_q
         && dp_q == {instr_q.byte2, instr_q.byte3};
   endproperty
   a_loadDp: assert property (p_loadDp)
      else $error("pointer load wrong");

   property p_idxImm;
      @(posedge clk) disable iff (!reset_n)
      startTaken && newOp == OP_IDX_IMM |-> ##1 iramWe
         && iramWdata == instr_q.byte2 ##1 done_q;
   endproperty
   a_idxImm: assert property (p_idxImm)
      else $error("immediate store wrong");

   property p_codeRdDp;
      @(posedge clk) disable iff (!reset_n)
      startTaken && newOp == OP_CODE_RD_DP |=> codeRd_q
         && codeAddr_q == $past(dp_q) + {8'h00, $past(accum_q)}
         ##1 !done_q ##2 done_q && accum_q == $past(codeRdata, 2);
   endproperty
   a_codeRdDp: assert property (p_codeRdDp)
      else $error("pointer code read wrong");

   property p_codeRdPc;
      @(posedge clk) disable iff (!reset_n)
      startTaken && newOp == OP_CODE_RD_PC |=> codeRd_q
         && codeAddr_q == $past(pc) + 16'h0001 + {8'h00, $past(accum_q)}
         && $stable(dp_q) ##3 done_q;
   endproperty
   a_codeRdPc: assert property (p_codeRdPc)
      else $error("counter code read wrong");

   property p_codeWr;
      @(posedge clk) disable iff (!reset_n)
      codeWr_q |-> codeAddr_q == $past(dp_q)
         ##3 done_q && dp_q == codeAddr_q + 16'h0001;
   endproperty
   a_codeWr: assert property (p_codeWr)
      else $error("code write pointer wrong");

   property p_trap;
      @(posedge clk) disable iff (!reset_n)
      start && state_q == ST_IDLE && instr.opcode == OPC_CODE_WR
         && trapEnableBit |=> trapReq && !codeWr_q && !busy;
   endproperty
   a_trap: assert property (p_trap)
      else $error("trap not taken");

   property p_xShort;
      @(posedge clk) disable iff (!reset_n)
      startTaken && (newOp == OP_XRD_IDX || newOp == OP_XWR_IDX)
         |=> (xRd_q || xWr_q) && xAddr_q[15:8] == $past(portHiLatch)
         && xAddr_q[7:0] == $past(idxValNew) ##3 done_q;
   endproperty
   a_xShort: assert property (p_xShort)
      else $error("short external move wrong");

   property p_xLong;
      @(posedge clk) disable iff (!reset_n)
      startTaken && (newOp == OP_XRD_DP || newOp == OP_XWR_DP)
         |=> (xRd_q || xWr_q) && xAddr_q == $past(dp_q) ##3 done_q;
   endproperty
   a_xLong: assert property (p_xLong)
      else $error("long external move wrong");

endmodule : dmx_data_move_exec

// ===== test/dmx_mem_model.sv
// Program and external data memory model for the data-move executor
`timescale 1ns/1ns
module dmx_mem_model (
   // Clock
   input  wire logic        clk,
   // Program memory
   input  wire logic [15:0] codeAddr,
   input  wire logic        codeRd,
   input  wire logic        codeWr,
   input  wire logic [7:0]  codeWdata,
   output logic      [7:0]  codeRdata,
   // External data memory
   input  wire logic [15:0] xAddr,
   input  wire logic        xRd,
   input  wire logic        xWr,
   input  wire logic [7:0]  xWdata,
   output logic      [7:0]  xRdata
);
   logic [7:0] pmem [0:65535];  // Code space
   logic [7:0] xmem [0:65535];  // External data space

   // Preload both spaces with address-derived patterns
   initial begin
      for (int a = 0; a < 65536; a++) begin
         pmem[a] = a[7:0] ^ a[15:8] ^ 8'h5a;
         xmem[a] = a[7:0] + a[15:8] + 8'h33;
      end
   end

   // Data valid one clock after a strobe, scrambled otherwise
   always @(posedge clk) begin
      codeRdata <= codeRd ? pmem[codeAddr] : ~codeRdata;
      xRdata <= xRd ? xmem[xAddr] : ~xRdata;
      if (codeWr) pmem[codeAddr] <= codeWdata;
      if (xWr) xmem[xAddr] <= xWdata;
   end
endmodule : dmx_mem_model

// ===== test/tb_data_move_instruction_exec.sv
// Self-checking bench for the data-move executor
`timescale 1ns/1ns
module tb_data_move_instruction_exec;
   import dmx_pkg::*;
   logic clk = 0, reset_n = 0, start = 0, trapEnableBit = 0;
   logic busy, done, trapReq, illegal, carry, sfrBitWr, sfrBitWdata;
   logic codeRd, codeWr, xRd, xWr, iramExtWe = 0, sfrBitIn = 0;
   logic [7:0] accumulator, sfrBitAddr, codeWdata, codeRdata, xWdata;
   logic [7:0] xRdata, iramExtAddr = 0, iramExtData = 0;
   logic [7:0] portHiLatch = 8'h7e, accumE;
   logic [15:0] pc = 0, dataPointer, codeAddr, xAddr, busAdr;
   logic [1:0] regBank = 2'h2;
   logic sawWr, sawSfr;
   dmx_instr_t instr = '0;
   int nErrors = 0, numChecks = 0;

   always #2 clk = ~clk;  // 250 MHz

   dmx_data_move_exec dut (.*);
   dmx_mem_model mem (.*);

   // Closing report
   task automatic wrap_up();
      $display("checks %0d errors %0d", numChecks, nErrors);
      if (nErrors == 0 && numChecks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : wrap_up

   // Value compare
   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      numChecks++;
      if (g !== e) begin
         nErrors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // Issue one instruction, watch its bus traffic, time its end
   task automatic run(dmx_instr_t ins, logic [15:0] p, int nExp);
      int n;
      @(posedge clk);
      start <= 1'b1;
      instr <= ins;
      pc <= p;
      @(posedge clk);
      start <= 1'b0;
      n = 0;
      sawWr = 0;
      sawSfr = 0;
      forever begin
         #1;
         n++;
         if (codeRd === 1'b1 || codeWr === 1'b1) busAdr = codeAddr;
         if (xRd === 1'b1 || xWr === 1'b1) busAdr = xAddr;
         if (codeWr === 1'b1 || xWr === 1'b1) sawWr = 1'b1;
         if (sfrBitWr === 1'b1) sawSfr = sfrBitWdata;
         if (n == 1 && nExp > 1) chk("busy", 1, {15'h0, busy});
         if (done === 1'b1 || trapReq === 1'b1 || illegal === 1'b1) break;
         if (n >= 12) begin
            nErrors++;
            wrap_up();
         end
         @(posedge clk);
      end
      chk("cycles", 16'(nExp), 16'(n));
   endtask : run

   // Drive the core-side RAM write port for one clock
   task automatic iram_wr(logic [7:0] a, logic [7:0] d);
      @(posedge clk);
      iramExtWe <= 1'b1;
      iramExtAddr <= a;
      iramExtData <= d;
      @(posedge clk);
      iramExtWe <= 1'b0;
   endtask : iram_wr

   initial begin
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      // Pointer load and pointer-relative code reads
      run({OPC_LOAD_DP, 8'h12, 8'hf0}, 16'h0100, 4);
      chk("dp", 16'h12f0, dataPointer);
      run({OPC_CODE_RD_DP, 16'h0}, 0, 4);
      accumE = 8'hb8;
      chk("accum", {8'h0, accumE}, {8'h0, accumulator});
      run({OPC_CODE_RD_DP, 16'h0}, 0, 4);
      chk("cadr", 16'h13a8, busAdr);
      accumE = 8'h13 ^ 8'ha8 ^ 8'h5a;
      chk("dp", 16'h12f0, dataPointer);
      // Counter-relative read across a byte carry
      run({OPC_CODE_RD_PC, 16'h0}, 16'h20ff, 4);
      chk("cadr", 16'h2100 + accumE, busAdr);
      accumE = 8'h21 ^ (8'h00 + accumE) ^ 8'h5a;
      chk("accum", {8'h0, accumE}, {8'h0, accumulator});
      // Code write, then the same opcode as trap
      run({OPC_CODE_WR, 16'h0}, 0, 4);
      chk("pmem", {8'h0, accumE}, {8'h0, mem.pmem[16'h12f0]});
      chk("dp", 16'h12f1, dataPointer);
      @(posedge clk) trapEnableBit <= 1'b1;
      run({OPC_CODE_WR, 16'h0}, 0, 1);
      chk("trap", 16'h1, {15'h0, trapReq});
      chk("dp", 16'h12f1, dataPointer);
      @(posedge clk) trapEnableBit <= 1'b0;
      // Bank 2 index registers point into RAM; the store lands there
      iram_wr(8'h11, 8'h44);
      iram_wr(8'h10, 8'h30);
      run({OPC_IDX_IMM_HI, 1'b1, 8'h5c, 8'h0}, 0, 2);
      chk("iram", 16'h005c, {8'h0, dut.iram[8'h44]});
      run({OPC_IDX_IMM_HI, 1'b0, 8'h10, 8'h0}, 0, 2);
      chk("iram", 16'h0010, {8'h0, dut.iram[8'h30]});
      // Short external moves keep the index values as addresses
      run({OPC_XRD_IDX_HI, 1'b1, 16'h0}, 0, 4);
      chk("xadr", 16'h7e44, busAdr);
      accumE = 8'h44 + 8'h7e + 8'h33;
      chk("accum", {8'h0, accumE}, {8'h0, accumulator});
      run({OPC_XWR_IDX_HI, 1'b0, 16'h0}, 0, 4);
      chk("xmem", {8'h0, accumE}, {8'h0, mem.xmem[16'h7e30]});
      // Long external moves through the pointer
      run({OPC_XRD_DP, 16'h0}, 0, 4);
      accumE = 8'hf1 + 8'h12 + 8'h33;
      chk("accum", {8'h0, accumE}, {8'h0, accumulator});
      run({OPC_XWR_DP, 16'h0}, 0, 4);
      chk("xadr", 16'h12f1, busAdr);
      chk("wr", 16'h1, {15'h0, sawWr});
      chk("xmem", {8'h0, accumE}, {8'h0, mem.xmem[16'h12f1]});
      // Bit moves between carry, special bits and RAM bits
      @(posedge clk) sfrBitIn <= 1'b1;
      run({OPC_BIT_TO_CARRY, 8'h85, 8'h0}, 0, 2);
      chk("carry", 16'h1, {15'h0, carry});
      chk("badr", 16'h0085, {8'h0, sfrBitAddr});
      run({OPC_CARRY_TO_BIT, 8'h03, 8'h0}, 0, 4);
      @(posedge clk) sfrBitIn <= 1'b0;
      iram_wr(8'h24, 8'h00);
      run({OPC_BIT_TO_CARRY, 8'h21, 8'h0}, 0, 2);
      chk("carry", 16'h0, {15'h0, carry});
      run({OPC_BIT_TO_CARRY, 8'h03, 8'h0}, 0, 2);
      chk("carry", 16'h1, {15'h0, carry});
      run({OPC_CARRY_TO_BIT, 8'h90, 8'h0}, 0, 4);
      chk("sfrwr", 16'h1, {15'h0, sawSfr});
      chk("accum", {8'h0, accumE}, {8'h0, accumulator});
      run({8'h00, 16'h0}, 0, 1);
      chk("illegal", 16'h1, {15'h0, illegal});
      wrap_up();
   end
endmodule : tb_data_move_instruction_exec
